// ### inc/spc_cfg.svh
// Constants of the satellite pair command port: timing, characters, name table.
// Assumes a 10 MHz system clock; included by the package user files.
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// ----------------------------------------
// Clock and serial framing
// ----------------------------------------
`define SPC_CLK_HZ 10_000_000
`define SPC_BAUD 9600
`define SPC_BIT_CYC (`SPC_CLK_HZ / `SPC_BAUD)
`define SPC_HALF_CYC (`SPC_BIT_CYC / 2)
`define SPC_DATA_BITS 8

// ----------------------------------------
// Diagnostic period and tone detector
// ----------------------------------------
`define SPC_DIAG_MS 1000
`define SPC_TONE_HZ 22_000
`define SPC_TONE_WIN_US 1000
`define SPC_TONE_MIN_EDGES (`SPC_TONE_HZ / 1000 * `SPC_TONE_WIN_US / 1000 / 2)

// ----------------------------------------
// Characters
// ----------------------------------------
`define SPC_CH_CR 8'h0D
`define SPC_CH_LF 8'h0A
`define SPC_CH_SPACE 8'h20
`define SPC_CH_COMMA 8'h2C
`define SPC_CH_A 8'h41
`define SPC_CH_B 8'h42
`define SPC_CH_D 8'h44
`define SPC_CH_E 8'h45
`define SPC_CH_K 8'h4B
`define SPC_CH_O 8'h4F
`define SPC_CH_R 8'h52

// ----------------------------------------
// Command keywords, upper case, right aligned
// ----------------------------------------
`define SPC_NAME_LEN 10
`define SPC_KW_HALT 80'h0000_0000_0000_4841_4C54
`define SPC_KW_PAIR 80'h5341_5449_4E53_5441_4C4C
`define SPC_KW_TRACK 80'h0000_0000_0000_0000_404C
`define SPC_KW_RESTART 80'h0000_0000_0000_005A_4150
`define SPC_KW_NONE 80'h0000_0000_0000_4E4F_4E45
`define SPC_KW_SLOT_A 80'h0000_0000_0000_0000_0041
`define SPC_KW_SLOT_B 80'h0000_0000_0000_0000_0042

// ----------------------------------------
// Satellite library, index is the satellite id
// ----------------------------------------
`define SPC_LIB_N 17
`define SPC_LIB_0 80'h0000_0000_4153_5452_4131
`define SPC_LIB_1 80'h0000_0041_5354_5241_324E
`define SPC_LIB_2 80'h0000_0041_5354_5241_3253
`define SPC_LIB_3 80'h0000_4849_5350_4153_4154
`define SPC_LIB_4 80'h0000_0048_4F54_4249_5244
`define SPC_LIB_5 80'h0000_0000_5349_5249_5553
`define SPC_LIB_6 80'h0000_0000_0000_5448_4F52
`define SPC_LIB_7 80'h0000_0044_5353_5F31_3031
`define SPC_LIB_8 80'h0000_0044_5353_5F31_3130
`define SPC_LIB_9 80'h0000_0044_5353_5F31_3139
`define SPC_LIB_10 80'h0000_0045_4348_4F5F_3631
`define SPC_LIB_11 80'h0000_4543_484F_5F31_3130
`define SPC_LIB_12 80'h0000_4543_484F_5F31_3139
`define SPC_LIB_13 80'h0000_4543_484F_5F31_3438
`define SPC_LIB_14 80'h0045_5850_5245_5353_5655
`define SPC_LIB_15 80'h0000_0000_0055_5345_5231
`define SPC_LIB_16 80'h0000_0000_0055_5345_5232

// ----------------------------------------
// Factory default pairs and reset values
// ----------------------------------------
`define SPC_DEF_EU_A 5'h00
`define SPC_DEF_EU_B 5'h04
`define SPC_DEF_NA_A 5'h07
`define SPC_DEF_NA_B 5'h09
`define SPC_RST_ID 5'h00

`endif

// ### inc/spc_pkg.sv
// Types shared by the satellite pair command port files.
// Assumes nothing beyond a SystemVerilog compiler.
package spc_pkg;

    // ----------------------------------------
    // Modes and messages
    // ----------------------------------------
    typedef enum logic {
        SPC_MODE_TRACK,
        SPC_MODE_IDLE
    } spc_mode_t;

    typedef enum logic [1:0] {
        SPC_MSG_OK,
        SPC_MSG_ERR,
        SPC_MSG_DIAG
    } spc_msg_t;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [4:0] sat_a;
        logic [4:0] sat_b;
        logic single;
    } spc_pair_t;

    typedef struct packed {
        logic track_en;
        logic slot_b;
        logic [4:0] sat_id;
    } spc_track_t;

endpackage : spc_pkg

// ### src/spc_buf.sv
// Small FIFO between the message engine and the serial transmitter.
// Assumes one clock; both sides use valid and ready.
module spc_buf #(
    parameter int W = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : spc_buf

// ### src/spc_cmd_port.sv
// Command interpreter behind the antenna maintenance serial port.
// Assumes rxd, tone_in, region_na and fault are synchronous to mclk.
`include "spc_cfg.svh"
module spc_cmd_port #(
    parameter int DIAG_CYC = `SPC_DIAG_MS * (`SPC_CLK_HZ / 1000),
    parameter int TONE_WIN = `SPC_TONE_WIN_US * (`SPC_CLK_HZ / 1_000_000)
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Maintenance serial port
    input wire logic rxd,
    output logic txd,
    // Strap, receiver tone and fault inputs
    input wire logic region_na,
    input wire logic tone_in,
    input wire logic [7:0] fault,
    // Antenna control
    output spc_pkg::spc_pair_t pair,
    output spc_pkg::spc_track_t track,
    output logic restart_pulse
);
    localparam logic [10:0] BIT_CYC = 11'(`SPC_BIT_CYC - 1);
    localparam logic [10:0] HALF_CYC = 11'(`SPC_HALF_CYC - 1);
    localparam logic [79:0] LIB [`SPC_LIB_N] = '{`SPC_LIB_0, `SPC_LIB_1, `SPC_LIB_2, `SPC_LIB_3,
        `SPC_LIB_4, `SPC_LIB_5, `SPC_LIB_6, `SPC_LIB_7, `SPC_LIB_8, `SPC_LIB_9, `SPC_LIB_10,
        `SPC_LIB_11, `SPC_LIB_12, `SPC_LIB_13, `SPC_LIB_14, `SPC_LIB_15, `SPC_LIB_16};

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} spc_rx_t;

    // ----------------------------------------
    // Serial receiver
    // ----------------------------------------
    spc_rx_t rx_st;
    logic [10:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_valid;
    logic rx_ferr;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_st <= RX_IDLE;
            rx_cnt <= 11'h000;
            rx_bit <= 3'h0;
            rx_sh <= 8'h00;
            rx_valid <= 1'b0;
            rx_ferr <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            rx_ferr <= 1'b0;
            if (rx_st != RX_IDLE && rx_cnt != 11'h000) begin
                rx_cnt <= rx_cnt - 11'h001;
            end else begin
                case (rx_st)
                    RX_IDLE: begin
                        if (!rxd) begin
                            rx_st <= RX_START;
                            rx_cnt <= HALF_CYC;
                        end
                    end
                    RX_START: begin
                        rx_st <= rxd ? RX_IDLE : RX_DATA;
                        rx_cnt <= BIT_CYC;
                        rx_bit <= 3'h0;
                    end
                    RX_DATA: begin
                        rx_sh <= {rxd, rx_sh[7:1]};
                        rx_cnt <= BIT_CYC;
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_bit == 3'(`SPC_DATA_BITS - 1)) begin
                            rx_st <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        rx_valid <= rxd;
                        rx_ferr <= !rxd;
                        rx_st <= RX_IDLE;
                    end
                    default: rx_st <= RX_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Line collector: up to three comma separated tokens
    // ----------------------------------------
    logic [7:0] ch;
    logic [79:0] tok [3];
    logic [1:0] ntok;
    logic [3:0] tlen;
    logic bad;
    logic eval;

    assign ch = (rx_sh >= 8'h61 && rx_sh <= 8'h7A) ? rx_sh - 8'h20 : rx_sh;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tok <= '{3{80'h0000_0000_0000_0000_0000}};
            ntok <= 2'h0;
            tlen <= 4'h0;
            bad <= 1'b0;
            eval <= 1'b0;
        end else begin
            eval <= 1'b0;
            if (eval) begin
                tok <= '{3{80'h0000_0000_0000_0000_0000}};
                ntok <= 2'h0;
                tlen <= 4'h0;
                bad <= 1'b0;
            end else if (rx_ferr) begin
                bad <= 1'b1;
            end else if (rx_valid) begin
                if (ch == `SPC_CH_CR) begin
                    eval <= 1'b1;
                end else if (ch == `SPC_CH_COMMA) begin
                    bad <= bad || (ntok == 2'h2);
                    ntok <= (ntok == 2'h2) ? ntok : ntok + 2'h1;
                    tlen <= 4'h0;
                end else if (ch != `SPC_CH_LF && ch != `SPC_CH_SPACE) begin
                    if (tlen == 4'(`SPC_NAME_LEN)) begin
                        bad <= 1'b1;
                    end else begin
                        tok[ntok] <= {tok[ntok][71:0], ch};
                        tlen <= tlen + 4'h1;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    function automatic logic [5:0] lib_find(input logic [79:0] name);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < `SPC_LIB_N; i++) begin
            if (name == LIB[i]) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction : lib_find

    spc_pkg::spc_mode_t mode;
    logic booted;
    logic slot_b;
    logic [5:0] find_a;
    logic [5:0] find_b;
    logic b_none;
    logic cmd_halt;
    logic cmd_pair;
    logic cmd_sel;
    logic cmd_restart;

    assign find_a = lib_find(tok[1]);
    assign find_b = lib_find(tok[2]);
    assign b_none = (tok[2] == `SPC_KW_NONE);
    assign cmd_halt = eval && !bad && ntok == 2'h0 && tok[0] == `SPC_KW_HALT;
    assign cmd_pair = eval && !bad && ntok == 2'h2 && tok[0] == `SPC_KW_PAIR
        && mode == spc_pkg::SPC_MODE_IDLE && find_a[5] && (find_b[5] || b_none);
    assign cmd_sel = eval && !bad && ntok == 2'h1 && tok[0] == `SPC_KW_TRACK
        && (tok[1] == `SPC_KW_SLOT_A || (tok[1] == `SPC_KW_SLOT_B && !pair.single));
    assign cmd_restart = eval && !bad && ntok == 2'h0 && tok[0] == `SPC_KW_RESTART;

    // Factory default on the first edge after reset, then on pair commands
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pair <= '{sat_a: `SPC_RST_ID, sat_b: `SPC_RST_ID, single: 1'b0};
            booted <= 1'b0;
        end else begin
            booted <= 1'b1;
            if (!booted) begin
                pair.sat_a <= region_na ? `SPC_DEF_NA_A : `SPC_DEF_EU_A;
                pair.sat_b <= region_na ? `SPC_DEF_NA_B : `SPC_DEF_EU_B;
                pair.single <= 1'b0;
            end else if (cmd_pair) begin
                pair.sat_a <= find_a[4:0];
                pair.sat_b <= b_none ? find_a[4:0] : find_b[4:0];
                pair.single <= b_none;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mode <= spc_pkg::SPC_MODE_TRACK;
            restart_pulse <= 1'b0;
        end else begin
            restart_pulse <= cmd_restart;
            if (cmd_halt) begin
                mode <= spc_pkg::SPC_MODE_IDLE;
            end else if (cmd_sel || cmd_restart) begin
                mode <= spc_pkg::SPC_MODE_TRACK;
            end
        end
    end

    // ----------------------------------------
    // Tone detector: rising edges counted per window
    // ----------------------------------------
    logic tone_prev;
    logic [$clog2(TONE_WIN+1)-1:0] win_cnt;
    logic [7:0] edge_cnt;
    logic tone_now;
    logic tone_seen;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tone_prev <= 1'b0;
            win_cnt <= '0;
            edge_cnt <= 8'h00;
            tone_now <= 1'b0;
            tone_seen <= 1'b0;
        end else begin
            tone_prev <= tone_in;
            tone_seen <= tone_now;
            if (win_cnt == $bits(win_cnt)'(TONE_WIN - 1)) begin
                win_cnt <= '0;
                edge_cnt <= 8'h00;
                tone_now <= (edge_cnt >= 8'(`SPC_TONE_MIN_EDGES));
            end else begin
                win_cnt <= win_cnt + 1'b1;
                if (tone_in && !tone_prev && edge_cnt != 8'hFF) begin
                    edge_cnt <= edge_cnt + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            slot_b <= 1'b0;
        end else if (cmd_sel) begin
            slot_b <= (tok[1] == `SPC_KW_SLOT_B);
        end else if (cmd_pair && b_none) begin
            slot_b <= 1'b0;
        end else if (mode == spc_pkg::SPC_MODE_TRACK && tone_now != tone_seen && !pair.single) begin
            slot_b <= tone_now;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            track <= '{track_en: 1'b0, slot_b: 1'b0, sat_id: `SPC_RST_ID};
        end else begin
            track.track_en <= booted && mode == spc_pkg::SPC_MODE_TRACK;
            track.slot_b <= slot_b;
            track.sat_id <= slot_b ? pair.sat_b : pair.sat_a;
        end
    end

    // ----------------------------------------
    // Message engine: answers and periodic diagnostics
    // ----------------------------------------
    logic resp_pend;
    spc_pkg::spc_msg_t resp_kind;
    logic diag_pend;
    logic [$clog2(DIAG_CYC+1)-1:0] diag_cnt;
    logic msg_busy;
    spc_pkg::spc_msg_t msg_kind;
    logic [2:0] msg_idx;
    logic [7:0] msg_fault;
    logic [7:0] msg_data;
    logic msg_last;
    logic msg_start;
    logic buf_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [9:0] tx_sh;
    logic [3:0] tx_bits;
    logic [10:0] tx_cnt;

    function automatic logic [7:0] hex(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction : hex

    always_comb begin
        msg_data = `SPC_CH_LF;
        case (msg_idx)
            3'h0: msg_data = (msg_kind == spc_pkg::SPC_MSG_OK) ? `SPC_CH_O
                : (msg_kind == spc_pkg::SPC_MSG_ERR) ? `SPC_CH_E : `SPC_CH_D;
            3'h1: msg_data = (msg_kind == spc_pkg::SPC_MSG_OK) ? `SPC_CH_K
                : (msg_kind == spc_pkg::SPC_MSG_ERR) ? `SPC_CH_R : hex(msg_fault[7:4]);
            3'h2: msg_data = (msg_kind == spc_pkg::SPC_MSG_DIAG) ? hex(msg_fault[3:0]) : `SPC_CH_CR;
            3'h3: msg_data = (msg_kind == spc_pkg::SPC_MSG_DIAG) ? `SPC_CH_CR : `SPC_CH_LF;
            default: msg_data = `SPC_CH_LF;
        endcase
    end

    assign msg_last = (msg_idx == ((msg_kind == spc_pkg::SPC_MSG_DIAG) ? 3'h4 : 3'h3));
    assign msg_start = !msg_busy && (resp_pend || diag_pend);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            resp_pend <= 1'b0;
            resp_kind <= spc_pkg::SPC_MSG_OK;
        end else if (eval) begin
            resp_pend <= 1'b1;
            resp_kind <= (cmd_halt || cmd_pair || cmd_sel || cmd_restart)
                ? spc_pkg::SPC_MSG_OK : spc_pkg::SPC_MSG_ERR;
        end else if (msg_start) begin
            resp_pend <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            diag_pend <= 1'b0;
            diag_cnt <= '0;
        end else begin
            diag_cnt <= (diag_cnt == $bits(diag_cnt)'(DIAG_CYC - 1)) ? '0 : diag_cnt + 1'b1;
            if (booted && diag_cnt == $bits(diag_cnt)'(DIAG_CYC - 1)) begin
                diag_pend <= 1'b1;
            end else if (msg_start && !resp_pend) begin
                diag_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            msg_busy <= 1'b0;
            msg_kind <= spc_pkg::SPC_MSG_OK;
            msg_idx <= 3'h0;
            msg_fault <= 8'h00;
        end else if (msg_start) begin
            msg_busy <= 1'b1;
            msg_kind <= resp_pend ? resp_kind : spc_pkg::SPC_MSG_DIAG;
            msg_idx <= 3'h0;
            msg_fault <= fault;
        end else if (msg_busy && buf_ready) begin
            msg_idx <= msg_idx + 3'h1;
            msg_busy <= !msg_last;
        end
    end

    spc_buf #(.W(8), .DEPTH(2)) u_buf (
        .mclk(mclk),
        .arst_n(arst_n),
        .in_valid(msg_busy),
        .in_ready(buf_ready),
        .in_data(msg_data),
        .out_valid(tx_valid),
        .out_ready(tx_bits == 4'h0),
        .out_data(tx_data)
    );

    // ----------------------------------------
    // Serial transmitter, line idles high
    // ----------------------------------------
    assign txd = tx_sh[0];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_sh <= 10'h3FF;
            tx_bits <= 4'h0;
            tx_cnt <= 11'h000;
        end else if (tx_bits == 4'h0) begin
            if (tx_valid) begin
                tx_sh <= {1'b1, tx_data, 1'b0};
                tx_bits <= 4'hA;
                tx_cnt <= BIT_CYC;
            end
        end else if (tx_cnt != 11'h000) begin
            tx_cnt <= tx_cnt - 11'h001;
        end else begin
            tx_sh <= {1'b1, tx_sh[9:1]};
            tx_bits <= tx_bits - 4'h1;
            tx_cnt <= BIT_CYC;
        end
    end

endmodule : spc_cmd_port

// ### tb/spc_cmd_port_properties.sv
// Pin-level checks for the satellite pair command port.
// Assumes it is bound onto spc_cmd_port and sees only its ports.
`include "spc_cfg.svh"
module spc_cmd_port_chk #(
    parameter int DIAG_CYC = 2000,
    parameter int TONE_WIN = 1000
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Serial, strap, tone, faults
    input wire logic rxd,
    input wire logic txd,
    input wire logic region_na,
    input wire logic tone_in,
    input wire logic [7:0] fault,
    // Antenna control
    input wire spc_pkg::spc_pair_t pair,
    input wire spc_pkg::spc_track_t track,
    input wire logic restart_pulse
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_default_sat_a: assert property (
        $rose(arst_n) |=> pair.sat_a == ($past(region_na) ? `SPC_DEF_NA_A : `SPC_DEF_EU_A))
        else $error("slot A default wrong after reset");
    a_default_sat_b: assert property (
        $rose(arst_n) |=> !pair.single && pair.sat_b == ($past(region_na) ? `SPC_DEF_NA_B : `SPC_DEF_EU_B))
        else $error("slot B default wrong after reset");
    a_reset_quiet: assert property (
        $rose(arst_n) |-> txd && !track.track_en && !restart_pulse)
        else $error("outputs not quiet in reset");
    a_boot_track: assert property (
        $rose(arst_n) |-> ##2 track.track_en && track.sat_id == pair.sat_a)
        else $error("no tracking of slot A after start");
    a_pulse_single: assert property (
        restart_pulse |=> !restart_pulse)
        else $error("restart pulse longer than one cycle");
    a_restart_tracks: assert property (
        restart_pulse |-> ##[0:2] track.track_en)
        else $error("restart did not resume tracking");
    a_sat_matches_slot: assert property (
        track.track_en |-> track.sat_id == (track.slot_b ? pair.sat_b : pair.sat_a))
        else $error("tracked id does not match slot");
    a_single_slot_a: assert property (
        pair.single && track.track_en |-> !track.slot_b)
        else $error("slot B tracked without a pair");
    a_start_bit_held: assert property (
        $fell(txd) |-> (!txd) [*8])
        else $error("start bit too short");
    a_pair_when_idle: assert property (
        $changed(pair) |-> !track.track_en)
        else $error("pair changed while tracking");
endmodule : spc_cmd_port_chk

bind spc_cmd_port spc_cmd_port_chk #(.DIAG_CYC(DIAG_CYC), .TONE_WIN(TONE_WIN)) i_chk (
    .mclk(mclk), .arst_n(arst_n), .rxd(rxd), .txd(txd), .region_na(region_na), .tone_in(tone_in),
    .fault(fault), .pair(pair), .track(track), .restart_pulse(restart_pulse));

// ### tb/spc_term.sv
// Terminal model on the maintenance serial port.
// Assumes the 10 MHz clock of the port; line idles high.
`include "spc_cfg.svh"
module spc_term (
    // Clock
    input wire logic mclk,
    // Serial lines
    output logic rxd,
    input wire logic txd
);
    timeunit 1ns;
    timeprecision 1ns;

    initial rxd = 1'b1;

    // Start, 8 data LSB first, stop
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk);
            #1;
            rxd = frame[i];
            repeat (`SPC_BIT_CYC - 1) @(posedge mclk);
        end
    endtask : send_byte

    // Bad stop bit returns unknown
    task automatic recv_byte(output logic [7:0] b);
        @(negedge txd);
        repeat (`SPC_HALF_CYC) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (`SPC_BIT_CYC) @(posedge mclk);
            b[i] = txd;
        end
        repeat (`SPC_BIT_CYC) @(posedge mclk);
        if (txd !== 1'b1) b = 8'hxx;
    endtask : recv_byte
endmodule : spc_term

// ### tb/testbench.sv
// Self-checking bench for the satellite pair command port.
// Assumes shortened diagnostic and tone-window parameters.
`include "spc_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WIN = 1000;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic rxd;
    logic txd;
    logic region_na = 1'b0;
    logic tone_in = 1'b0;
    logic tone_on = 1'b0;
    logic [7:0] fault = 8'h3C;
    spc_pkg::spc_pair_t pair;
    spc_pkg::spc_track_t track;
    logic restart_pulse;
    int miscompares = 0;
    int n_compared = 0;
    int n_pulse = 0;
    int tph = 0;

    always #50 mclk = ~mclk;

    spc_cmd_port #(.DIAG_CYC(2000), .TONE_WIN(WIN)) i_dut (
        .mclk(mclk), .arst_n(arst_n), .rxd(rxd), .txd(txd), .region_na(region_na), .tone_in(tone_in),
        .fault(fault), .pair(pair), .track(track), .restart_pulse(restart_pulse));
    spc_term i_term (.mclk(mclk), .rxd(rxd), .txd(txd));

    always @(posedge mclk) begin
        if (restart_pulse === 1'b1) n_pulse++;
    end

    // Receiver tone, period 44 cycles
    always begin
        @(posedge mclk);
        #1;
        tph = (tph == 21) ? 0 : tph + 1;
        tone_in = tone_on ? (tph == 0 ? ~tone_in : tone_in) : 1'b0;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (miscompares == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic t_defaults(input logic na, input logic [4:0] a, input logic [4:0] b);
        @(posedge mclk);
        #1;
        arst_n = 1'b0;
        region_na = na;
        repeat (6) @(posedge mclk);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check(pair.sat_a, a);
        check(pair.sat_b, b);
        check(pair.single, 1'b0);
        check(track.track_en, 1'b1);
        check(track.sat_id, a);
    endtask : t_defaults

    task automatic t_tone();
        tone_on = 1'b1;
        repeat (2 * WIN + 10) @(posedge mclk);
        #1;
        check(track.slot_b, 1'b1);
        check(track.sat_id, `SPC_DEF_EU_B);
        tone_on = 1'b0;
        repeat (2 * WIN + 10) @(posedge mclk);
        #1;
        check(track.slot_b, 1'b0);
        check(track.sat_id, `SPC_DEF_EU_A);
    endtask : t_tone

    // Slot B select, then restart, while the first diagnostic line goes out
    task automatic t_restart_diag();
        logic [7:0] c;
        logic [7:0] cmd [9];
        cmd = '{8'h40, 8'h4C, `SPC_CH_COMMA, `SPC_CH_B, `SPC_CH_CR, 8'h5A, `SPC_CH_A, 8'h50, `SPC_CH_CR};
        fork
            begin
                for (int i = 0; i < 9; i++) i_term.send_byte(cmd[i]);
            end
            begin
                i_term.recv_byte(c);
                check(c, 8'h44);
                i_term.recv_byte(c);
                check(c, 8'h33);
                i_term.recv_byte(c);
                check(c, 8'h43);
            end
        join
        repeat (50) @(posedge mclk);
        #1;
        check(16'(n_pulse), 16'h0001);
        check(track.track_en, 1'b1);
        check(track.slot_b, 1'b1);
        check(track.sat_id, `SPC_DEF_NA_B);
    endtask : t_restart_diag

    initial begin
        t_defaults(1'b0, `SPC_DEF_EU_A, `SPC_DEF_EU_B);
        t_tone();
        t_defaults(1'b1, `SPC_DEF_NA_A, `SPC_DEF_NA_B);
        t_restart_diag();
        tally_and_finish();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        miscompares++;
        tally_and_finish();
    end
endmodule : testbench
